/* rtl/sacc_defines.vh */
// constants for the converter control block
`ifndef SACC_DEFINES_VH
`define SACC_DEFINES_VH
`define SACC_ADDR_LIMIT_LO   8'hc5
`define SACC_ADDR_LIMIT_HI   8'hc6
`define SACC_ADDR_CONTROL    8'he8
`define SACC_RESET_BYTE      8'h00
`define SACC_BIT_ON          7
`define SACC_BIT_TRACK_DELAY 6
`define SACC_BIT_DONE        5
`define SACC_BIT_ACTIVE      4
`define SACC_BIT_WINDOW      3
`define SACC_SRC_WRITE       3'h0
`define SACC_SRC_TIMER2      3'h2
`define SACC_SRC_TIMER1      3'h3
`define SACC_SRC_EXTERNAL    3'h4
`define SACC_SRC_TIMER3      3'h5
`define SACC_TRACK_DELAY_CYC 2'h3
`define SACC_RESOLUTION      10
`define SACC_CONVERT_CYC     5'h0d
`endif

/* rtl/sacc_pin_sync.v */
// three-flop synchroniser with agreement filter and rising edge detect
`timescale 1ns/1ps
module sacc_pin_sync
(
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // pin and filtered outputs
  input  wire pin,
  output reg  level_q,
  output wire rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg prev_q;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      prev_q <= level_q;
      // a change counts once stages two and three agree
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end

  assign rise = level_q & ~prev_q;
endmodule

/* rtl/sacc_window.v */
// less-than window comparison against the threshold word
`timescale 1ns/1ps
module sacc_window
#(
  parameter WIDTH = 10
)
(
  // result and threshold
  input  wire [WIDTH-1:0] result,
  input  wire [15:0]      limit,
  output wire             below
);
  assign below = ({6'h00, result} < limit);
endmodule

/* rtl/sacc_control.v */
// converter control: register file, start selection, track and convert
`timescale 1ns/1ps
//-----------------------------------------------------------------------
// Overview of operation
//-----------------------------------------------------------------------
`include "sacc_defines.vh"
module sacc_control
#(
  parameter RES_BITS = `SACC_RESOLUTION
)
(
  // clock and reset
  input  wire                CLOCK,
  input  wire                RST_N,
  // special function register bus
  input  wire [7:0]          SFR_ADDR,
  input  wire                SFR_WR,
  input  wire                SFR_BIT_WR,
  input  wire [2:0]          SFR_BIT_SEL,
  input  wire [7:0]          SFR_WDATA,
  output reg  [7:0]          SFR_RDATA,
  // start triggers
  input  wire                TIMER1_OVF,
  input  wire                TIMER2_OVF,
  input  wire                TIMER3_OVF,
  input  wire                EXTERNAL_START_TRIGGER,
  // analog front end
  input  wire                COMPARE_IN,
  output wire                CONVERTER_ON,
  output wire                TRACKING,
  output reg  [RES_BITS-1:0] RESULT,
  output reg                 RESULT_VALID
);
  //---------------------------------------------------------------------
  // state
  //---------------------------------------------------------------------
  localparam ST_IDLE    = 2'h0;
  localparam ST_TRACK   = 2'h1;
  localparam ST_CONVERT = 2'h2;

  reg [7:0]          ctrl_q;
  reg [7:0]          limit_lo_q;
  reg [7:0]          limit_hi_q;
  reg [1:0]          state_q;
  reg [1:0]          track_cnt_q;
  reg [4:0]          bit_cnt_q;
  reg [RES_BITS-1:0] sar_q;
  wire               ext_level;
  wire               ext_rise;
  wire               below;
  reg                start_evt;
  reg [7:0]          ctrl_wr_val;
  reg                ctrl_written;
  wire               finish;

  sacc_pin_sync u_sync
  (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .pin     (EXTERNAL_START_TRIGGER),
    .level_q (ext_level),
    .rise    (ext_rise)
  );

  sacc_window #(.WIDTH(RES_BITS)) u_window
  (
    .result (sar_q),
    .limit  ({limit_hi_q, limit_lo_q}),
    .below  (below)
  );

  // merge a bit write into the current byte
  function [7:0] bit_merge;
    input [7:0] cur;
    input [2:0] sel;
    input       val;
    begin
      bit_merge      = cur;
      bit_merge[sel] = val;
    end
  endfunction

  //---------------------------------------------------------------------
  // bus decode
  //---------------------------------------------------------------------
  always @*
  begin
    ctrl_written = (SFR_WR | SFR_BIT_WR) &&
                   (SFR_ADDR == `SACC_ADDR_CONTROL);
    if (SFR_BIT_WR)
      ctrl_wr_val = bit_merge(ctrl_q, SFR_BIT_SEL,
                              SFR_WDATA[0]);
    else
      ctrl_wr_val = SFR_WDATA;
  end

  always @*
  begin
    case (SFR_ADDR)
      `SACC_ADDR_CONTROL:  SFR_RDATA = ctrl_q;
      `SACC_ADDR_LIMIT_LO: SFR_RDATA = limit_lo_q;
      `SACC_ADDR_LIMIT_HI: SFR_RDATA = limit_hi_q;
      default:             SFR_RDATA = 8'h00;
    endcase
  end

  //---------------------------------------------------------------------
  // start selection
  //---------------------------------------------------------------------
  always @*
  begin
    case (ctrl_q[2:0])
      `SACC_SRC_WRITE:
        start_evt = ctrl_written &&
                    ctrl_wr_val[`SACC_BIT_ACTIVE] &&
                    (!SFR_BIT_WR ||
                     SFR_BIT_SEL == `SACC_BIT_ACTIVE) &&
                    (SFR_WR ? SFR_WDATA[`SACC_BIT_ACTIVE]
                            : SFR_WDATA[0]);
      `SACC_SRC_TIMER2:   start_evt = TIMER2_OVF;
      `SACC_SRC_TIMER1:   start_evt = TIMER1_OVF;
      `SACC_SRC_EXTERNAL: start_evt = ext_rise;
      `SACC_SRC_TIMER3:   start_evt = TIMER3_OVF;
      default:            start_evt = 1'b0;
    endcase
  end

  assign finish = (state_q == ST_CONVERT) &&
                  (bit_cnt_q == `SACC_CONVERT_CYC - 5'h01);

  //---------------------------------------------------------------------
  // registers and sequencer
  //---------------------------------------------------------------------
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_q       <= `SACC_RESET_BYTE;
      limit_lo_q   <= `SACC_RESET_BYTE;
      limit_hi_q   <= `SACC_RESET_BYTE;
      state_q      <= ST_IDLE;
      track_cnt_q  <= 2'h0;
      bit_cnt_q    <= 5'h00;
      sar_q        <= {RES_BITS{1'b0}};
      RESULT       <= {RES_BITS{1'b0}};
      RESULT_VALID <= 1'b0;
    end
    else
    begin
      RESULT_VALID <= 1'b0;
      if (SFR_WR && SFR_ADDR == `SACC_ADDR_LIMIT_LO)
        limit_lo_q <= SFR_WDATA;
      if (SFR_WR && SFR_ADDR == `SACC_ADDR_LIMIT_HI)
        limit_hi_q <= SFR_WDATA;
      if (ctrl_written)
      begin
        ctrl_q[7:5] <= ctrl_wr_val[7:5];
        ctrl_q[3:0] <= ctrl_wr_val[3:0];
        // busy is hardware owned; a write of 0 has no effect
      end
      case (state_q)
        ST_IDLE:
        begin
          if (ctrl_q[`SACC_BIT_ON] && start_evt)
          begin
            ctrl_q[`SACC_BIT_ACTIVE] <= 1'b1;
            bit_cnt_q <= 5'h00;
            sar_q     <= {1'b1, {(RES_BITS-1){1'b0}}};
            if (ctrl_q[`SACC_BIT_TRACK_DELAY])
            begin
              track_cnt_q <= 2'h0;
              state_q     <= ST_TRACK;
            end
            else
              state_q <= ST_CONVERT;
          end
        end
        ST_TRACK:
        begin
          track_cnt_q <= track_cnt_q + 2'h1;
          if (track_cnt_q == `SACC_TRACK_DELAY_CYC - 2'h1)
            state_q <= ST_CONVERT;
        end
        ST_CONVERT:
        begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          // successive approximation, one bit per cycle
          if (bit_cnt_q < RES_BITS)
          begin
            sar_q[RES_BITS-1-bit_cnt_q] <= COMPARE_IN;
            if (bit_cnt_q < RES_BITS - 1)
              sar_q[RES_BITS-2-bit_cnt_q] <= 1'b1;
          end
          if (finish)
          begin
            state_q      <= ST_IDLE;
            RESULT       <= sar_q;
            RESULT_VALID <= 1'b1;
            ctrl_q[`SACC_BIT_ACTIVE] <= 1'b0;
            ctrl_q[`SACC_BIT_DONE]   <= 1'b1;
            if (below)
              ctrl_q[`SACC_BIT_WINDOW] <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (!ctrl_q[`SACC_BIT_ON])
      begin
        state_q                  <= ST_IDLE;
        ctrl_q[`SACC_BIT_ACTIVE] <= 1'b0;
      end
    end
  end

  assign CONVERTER_ON = ctrl_q[`SACC_BIT_ON];
  // tracking: internal sources whenever idle; external pin per delay bit
  assign TRACKING = ctrl_q[`SACC_BIT_ON] &&
                    (state_q == ST_TRACK ||
                     (state_q == ST_IDLE &&
                      (ctrl_q[2:0] != `SACC_SRC_EXTERNAL ||
                       ctrl_q[`SACC_BIT_TRACK_DELAY] ||
                       !ext_level)));
endmodule

/* verif/sacc_control_assertions.sv */
// port assertions for the converter control block
`timescale 1ns/1ps
`include "sacc_defines.vh"
module sacc_control_assertions
#(
  parameter RES_BITS = 10
)
(
  // clock and reset
  input wire                CLOCK,
  input wire                RST_N,
  // register bus and pin
  input wire [7:0]          SFR_ADDR,
  input wire                SFR_WR,
  input wire [7:0]          SFR_WDATA,
  input wire                EXTERNAL_START_TRIGGER,
  // converter side
  input wire                CONVERTER_ON,
  input wire                TRACKING,
  input wire [RES_BITS-1:0] RESULT,
  input wire                RESULT_VALID
);
  wire       ctl = SFR_WR && SFR_ADDR == `SACC_ADDR_CONTROL;
  wire       go = ctl && TRACKING;
  wire [7:0] m = SFR_WDATA & 8'hd7;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  a_on_follows: assert property (ctl |=> CONVERTER_ON == $past(SFR_WDATA[7]))
    else $error("enable output wrong");
  a_go_now: assert property (go && m == 8'h90 |=> !TRACKING)
    else $error("tracking after start");
  a_delay_track: assert property (go && m == 8'hd0 |=> TRACKING [*3] ##1 !TRACKING)
    else $error("delayed tracking wrong");
  a_done_time: assert property (go && m == 8'h90 |-> ##[13:14] RESULT_VALID)
    else $error("conversion end late");
  a_idle_tracks: assert property (RESULT_VALID && !EXTERNAL_START_TRIGGER |-> TRACKING)
    else $error("not tracking when idle");
  a_valid_on: assert property (RESULT_VALID |-> CONVERTER_ON)
    else $error("result while off");
  a_no_double: assert property (RESULT_VALID |=> !RESULT_VALID [*8])
    else $error("results too close");
  a_result_hold: assert property (!RESULT_VALID |-> $stable(RESULT))
    else $error("result changed");
endmodule
bind sacc_control sacc_control_assertions #(.RES_BITS(RES_BITS)) u_sva (
  .CLOCK(CLOCK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
  .SFR_WDATA(SFR_WDATA), .EXTERNAL_START_TRIGGER(EXTERNAL_START_TRIGGER),
  .CONVERTER_ON(CONVERTER_ON), .TRACKING(TRACKING), .RESULT(RESULT),
  .RESULT_VALID(RESULT_VALID));

/* verif/sacc_cpu.sv */
// core model: register bus cycles and timer overflow pulses
`timescale 1ns/1ps
module sacc_cpu
(
  // clock
  input  wire       clk,
  // register bus
  output reg  [7:0] addr,
  output reg        wr,
  output reg        bwr,
  output reg  [2:0] bsel,
  output reg  [7:0] wdata,
  input  wire [7:0] rdata,
  // timers
  output reg  [2:0] ovf
);
  initial
    {addr, wr, bwr, bsel, ovf, wdata} = 24'h00005a;
  // byte or bit write; data inverted once released
  task w(input [7:0] a, input [7:0] d, input b, input [2:0] s);
    @(negedge clk);
    {addr, wdata, bsel} = {a, d, s};
    {wr, bwr} = {!b, b};
    @(negedge clk);
    {wr, bwr} = 2'b00;
    wdata = ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(negedge clk);
    addr = a;
    // read data is combinational; take it while settled, before the edge
    #1;
    d = rdata;
    @(posedge clk);
  endtask
  task pulse(input [2:0] p);
    @(negedge clk);
    ovf = p;
    @(negedge clk);
    ovf = 3'h0;
  endtask
endmodule

/* verif/sacc_control_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sacc_defines.vh"
`define CMP(n, e, s) \
  begin \
    checked++; \
    if ((s) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value %s exp %h got %h", n, e, s); \
    end \
  end
module sacc_control_tb;
  localparam [7:0] ct = `SACC_ADDR_CONTROL;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         pin = 1'b0;
  reg         cmp = 1'b0;
  reg  [31:0] seed = 32'h4d03;
  reg  [31:0] amap = {8'hc5, 8'hc6, 8'he8, 8'h33};
  reg  [9:0]  expq[$];
  reg  [9:0]  e;
  reg  [7:0]  v;
  wire [7:0]  addr, wdata, rdata;
  wire [2:0]  bsel, ovf;
  wire        wr, bwr, on, vld;
  wire [9:0]  res;
  integer     bad_count = 0;
  integer     checked = 0;
  integer     ndone = 0;
  integer     cyc = 0;
  integer     i, k, n;
  always #4 clk = ~clk;
  sacc_cpu u_cpu (.clk(clk), .addr(addr), .wr(wr), .bwr(bwr), .bsel(bsel),
    .wdata(wdata), .rdata(rdata), .ovf(ovf));
  sacc_control dut (.CLOCK(clk), .RST_N(rst_n), .SFR_ADDR(addr),
    .SFR_WR(wr), .SFR_BIT_WR(bwr), .SFR_BIT_SEL(bsel), .SFR_WDATA(wdata),
    .SFR_RDATA(rdata), .TIMER1_OVF(ovf[0]), .TIMER2_OVF(ovf[1]),
    .TIMER3_OVF(ovf[2]), .EXTERNAL_START_TRIGGER(pin), .COMPARE_IN(cmp),
    .CONVERTER_ON(on), .TRACKING(), .RESULT(res), .RESULT_VALID(vld));
  function [31:0] nxt(input [31:0] x);
    nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // result monitor takes the oldest note, away from the launching edge
  always @(negedge clk)
    if (vld === 1'b1)
    begin
      ndone++;
      e = (expq.size() != 0) ? expq.pop_front() : 10'h2aa;
      `CMP("result", e, res)
    end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // starts that must be ignored, abort when stop clears the enable
  task quiet(input [7:0] c, input [7:0] stop);
    n = ndone;
    u_cpu.w(ct, c, 1'b0, 3'h0);
    u_cpu.w(ct, 8'h00, 1'b1, 3'h4);
    u_cpu.pulse(3'h7);
    u_cpu.w(ct, stop, 1'b0, 3'h0);
    pin = 1'b1;
    repeat (40) @(negedge clk);
    pin = 1'b0;
    `CMP("done count", n, ndone)
    `CMP("enable out", stop[7], on)
    $display("quiet test %h done", c);
  endtask
  task conv(input [2:0] s, input d);
    reg [7:0]  c;
    reg [15:0] lim;
    reg [9:0]  r;
    seed = nxt(seed);
    c = {1'b1, d, 3'h0, s};
    lim = {5'h0, seed[10:8], seed[23:16]};
    r = {10{seed[0]}};
    @(negedge clk);
    cmp = seed[0];
    expq.push_back(r);
    u_cpu.w(`SACC_ADDR_LIMIT_HI, lim[15:8], 1'b0, 3'h0);
    u_cpu.w(`SACC_ADDR_LIMIT_LO, lim[7:0], 1'b0, 3'h0);
    u_cpu.rd(`SACC_ADDR_LIMIT_HI, v);
    `CMP("limit high", lim[15:8], v)
    u_cpu.w(ct, c, 1'b0, 3'h0);
    n = ndone;
    case (s)
      3'h0: u_cpu.w(ct, c | 8'h10, 1'b0, 3'h0);
      3'h2: u_cpu.pulse(3'h2);
      3'h3: u_cpu.pulse(3'h1);
      3'h4: pin = 1'b1;
      default: u_cpu.pulse(3'h4);
    endcase
    repeat (8) @(negedge clk);
    pin = 1'b0;
    u_cpu.rd(ct, v);
    `CMP("busy", 1'b1, v[4])
    u_cpu.pulse(3'h7);
    for (k = 0; k < 40 && ndone == n; k++)
      @(negedge clk);
    `CMP("done count", n + 1, ndone)
    u_cpu.rd(ct, v);
    `CMP("control", {c[7:6], 2'b10, {6'h0, r} < lim, s}, v)
    u_cpu.w(ct, 8'h00, 1'b1, 3'h5);
    u_cpu.w(ct, 8'h00, 1'b1, 3'h3);
    u_cpu.rd(ct, v);
    `CMP("cleared", c, v)
    $display("conversion test %h %b done", s, d);
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      u_cpu.rd(amap[8*i +: 8], v);
      `CMP("reset value", `SACC_RESET_BYTE, v)
    end
    quiet(8'h91, 8'h91);
    quiet(8'h96, 8'h96);
    quiet(8'h97, 8'h97);
    quiet(8'h12, 8'h12);
    quiet(8'h82, 8'h02);
    quiet(8'h80, 8'h80);
    // odd passes use delayed tracking
    for (i = 0; i < 10; i++)
      conv(i < 2 ? 3'h0 : 3'(i / 2 + 1), i[0]);
    end_sim;
  end
endmodule
